// file: logic/ssic_pkg.sv
package ssic_pkg;

    // Widths of the release, priority and stabilization inputs
    localparam int EXT_IRQ_W    = 7;
    localparam int PERIPH_IRQ_W = 8;
    localparam int PRIO_W       = 3;
    localparam int STAB_W       = 16;

    // Power-save select encoding
    localparam logic SEL_IDLE = 1'b0;
    localparam logic SEL_STOP = 1'b1;

    // A release mask bit at this value disables the source
    localparam logic MASK_OFF = 1'b1;

    // Stabilization counter constants
    localparam logic [STAB_W-1:0] STAB_ZERO = 16'h0000;
    localparam logic [STAB_W-1:0] STAB_ONE  = 16'h0001;

    // Normal and standby modes
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_IDLE   = 2'b01,
        ST_STOP   = 2'b10,
        ST_STAB   = 2'b11
    } ssic_mode_t;

endpackage : ssic_pkg

// file: logic/ssic_stab_cnt.sv
`timescale 1ns/1ns
module ssic_stab_cnt
(
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // Start and length
    input  wire logic                        load,
    input  wire logic [ssic_pkg::STAB_W-1:0] load_value,
    // One-cycle pulse when the interval has run out
    output logic                             done
);

    typedef struct packed {
        logic [ssic_pkg::STAB_W-1:0] count;
        logic                        busy;
        logic                        done;
    } ssic_cnt_state_t;

    ssic_cnt_state_t cnt_ff;
    ssic_cnt_state_t nxt_cnt;

    always_comb
    begin
        nxt_cnt      = cnt_ff;
        nxt_cnt.done = 1'b0;
        if (load)
        begin
            // A zero length still waits one cycle
            nxt_cnt.busy  = 1'b1;
            nxt_cnt.count = (load_value == ssic_pkg::STAB_ZERO) ?
                            ssic_pkg::STAB_ONE : load_value;
        end
        else if (cnt_ff.busy)
        begin
            if (cnt_ff.count == ssic_pkg::STAB_ONE)
            begin
                nxt_cnt.busy = 1'b0;
                nxt_cnt.done = 1'b1;
            end
            nxt_cnt.count = cnt_ff.count - ssic_pkg::STAB_ONE;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    assign done = cnt_ff.done;

endmodule : ssic_stab_cnt

// file: logic/ssic_ctrl.sv
// Summary of operation
// - Standby entered only from normal, trigger with select 1 gives stop
// - Stop halts main oscillator; subclock oscillator keeps running
// - Stop withholds CPU and main-clocked peripheral clocks
// - Subclock or external clocked units keep running in stop
// - Stop halts execution and freezes internal RAM
// - Stop released by NMI pin, watchdog, unmasked pin or peripheral
// - After stop release wait stabilization before clocking the CPU
// - Any unmasked request releases regardless of its priority
// - Lower-priority request during service only releases, no acknowledge
// - Higher-priority request with interrupts enabled, or non-maskable request, releases and is acknowledged
// - NMI branches to handler; maskable branches or continues
// - A request whose release mask bit is 1 does not release
// - Idle holds port pin levels and states
// - Idle keeps CPU registers, status and RAM unchanged
// - Idle real-time output runs on timer trigger, buffers not written
// - Idle: first async unit only on external baud clock, second stops
// - Idle: clocked serial only on external clock; others stop
// - Watchdog reset in standby acts as ordinary reset
`timescale 1ns/1ns
module ssic_ctrl
(
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // Standby control from software
    input  wire logic                              power_save_select,
    input  wire logic                              stop_trigger,
    input  wire logic                              wdt_nmi_release_mask,
    input  wire logic                              pin_nmi_release_mask,
    input  wire logic                              maskable_release_mask,
    input  wire logic [ssic_pkg::STAB_W-1:0]       stab_cycles,
    // Release sources
    input  wire logic                              nmi_pin,
    input  wire logic                              on_subclock,
    input  wire logic                              second_watchdog_irq,
    input  wire logic                              second_watchdog_reset,
    input  wire logic [ssic_pkg::EXT_IRQ_W-1:0]    ext_irq,
    input  wire logic [ssic_pkg::EXT_IRQ_W-1:0]    ext_irq_mask,
    input  wire logic [ssic_pkg::PERIPH_IRQ_W-1:0] periph_irq,
    input  wire logic [ssic_pkg::PERIPH_IRQ_W-1:0] periph_irq_mask,
    // CPU interrupt context
    input  wire logic                              irq_enabled,
    input  wire logic                              in_service,
    input  wire logic [ssic_pkg::PRIO_W-1:0]       service_priority,
    input  wire logic [ssic_pkg::PRIO_W-1:0]       request_priority,
    // Unit clock selections seen in idle
    input  wire logic                              uart_ext_baud_clock,
    input  wire logic                              csi_ext_serial_clock_a,
    input  wire logic                              csi_ext_serial_clock_b,
    input  wire logic                              rto_on_timer8_irq,
    input  wire logic                              timer8_idle_enable,
    // Clock and oscillator controls
    output logic                                   main_osc_en,
    output logic                                   sub_osc_en,
    output logic                                   cpu_clk_en,
    output logic                                   periph_clk_en,
    // Retention controls
    output logic                                   port_hold,
    output logic                                   state_freeze,
    // Unit run enables
    output logic                                   rto_run,
    output logic                                   rto_buffer_wr_en,
    output logic                                   async_serial_a_run,
    output logic                                   async_serial_b_run,
    output logic                                   clocked_serial_a_run,
    output logic                                   clocked_serial_b_run,
    output logic                                   auto_transfer_run,
    output logic                                   two_wire_run,
    output logic                                   adc_allow,
    output logic                                   key_irq_en,
    output logic                                   regulator_en,
    // Wake-up results, one-cycle pulses
    output logic                                   wake_done,
    output logic                                   nmi_branch,
    output logic                                   irq_ack,
    output logic                                   reset_req,
    // Current mode
    output ssic_pkg::ssic_mode_t                   mode
);

    typedef struct packed {
        ssic_pkg::ssic_mode_t mode;
        logic                 main_osc_en;
        logic                 sub_osc_en;
        logic                 cpu_clk_en;
        logic                 periph_clk_en;
        logic                 port_hold;
        logic                 state_freeze;
        logic                 rto_run;
        logic                 rto_buffer_wr_en;
        logic                 uart_a_run;
        logic                 uart_b_run;
        logic                 csi_a_run;
        logic                 csi_b_run;
        logic                 auto_xfer_run;
        logic                 two_wire_run;
        logic                 adc_allow;
        logic                 key_irq_en;
        logic                 regulator_en;
        logic                 stab_load;
        logic                 wake_nmi;
        logic                 wake_ack_ok;
        logic                 wake_done;
        logic                 nmi_branch;
        logic                 irq_ack;
        logic                 reset_req;
    } ssic_ctrl_state_t;

    localparam ssic_ctrl_state_t RST_STATE = '{
        mode:             ssic_pkg::ST_NORMAL,
        main_osc_en:      1'b1,
        sub_osc_en:       1'b1,
        cpu_clk_en:       1'b1,
        periph_clk_en:    1'b1,
        rto_run:          1'b1,
        rto_buffer_wr_en: 1'b1,
        uart_a_run:       1'b1,
        uart_b_run:       1'b1,
        csi_a_run:        1'b1,
        csi_b_run:        1'b1,
        auto_xfer_run:    1'b1,
        two_wire_run:     1'b1,
        adc_allow:        1'b1,
        key_irq_en:       1'b1,
        regulator_en:     1'b1,
        default:          1'b0
    };

    ssic_ctrl_state_t st_ff;
    ssic_ctrl_state_t nxt_st;
    logic             stab_done;
    logic             nmi_req;
    logic             maskable_req;
    logic             wake_any;
    logic             higher_prio;
    logic             ack_now;
    logic             wdt_rst_hit;

    // Release qualification, masked sources are ignored
    always_comb
    begin
        nmi_req = (nmi_pin && pin_nmi_release_mask != ssic_pkg::MASK_OFF) ||
                  (second_watchdog_irq && on_subclock &&
                   wdt_nmi_release_mask != ssic_pkg::MASK_OFF);
        maskable_req = ((|(ext_irq & ~ext_irq_mask)) ||
                        (|(periph_irq & ~periph_irq_mask))) &&
                       maskable_release_mask != ssic_pkg::MASK_OFF;
        wake_any     = nmi_req || maskable_req;
        // Lower priority number wins
        higher_prio  = !in_service ||
                       (request_priority < service_priority);
        ack_now      = nmi_req || (higher_prio && irq_enabled);
        wdt_rst_hit  = second_watchdog_reset && on_subclock &&
                       st_ff.mode != ssic_pkg::ST_NORMAL;
    end

    always_comb
    begin
        nxt_st            = st_ff;
        nxt_st.stab_load  = 1'b0;
        nxt_st.wake_done  = 1'b0;
        nxt_st.nmi_branch = 1'b0;
        nxt_st.irq_ack    = 1'b0;
        nxt_st.reset_req  = 1'b0;
        case (st_ff.mode)
            ssic_pkg::ST_NORMAL:
            begin
                if (stop_trigger)
                    nxt_st.mode = (power_save_select == ssic_pkg::SEL_STOP) ?
                                  ssic_pkg::ST_STOP : ssic_pkg::ST_IDLE;
            end
            ssic_pkg::ST_IDLE:
            begin
                if (wake_any)
                begin
                    nxt_st.mode       = ssic_pkg::ST_NORMAL;
                    nxt_st.wake_done  = 1'b1;
                    nxt_st.nmi_branch = nmi_req;
                    nxt_st.irq_ack    = !nmi_req && ack_now;
                end
            end
            ssic_pkg::ST_STOP:
            begin
                if (wake_any)
                begin
                    nxt_st.mode        = ssic_pkg::ST_STAB;
                    nxt_st.stab_load   = 1'b1;
                    nxt_st.wake_nmi    = nmi_req;
                    nxt_st.wake_ack_ok = ack_now;
                end
            end
            ssic_pkg::ST_STAB:
            begin
                if (stab_done)
                begin
                    nxt_st.mode       = ssic_pkg::ST_NORMAL;
                    nxt_st.wake_done  = 1'b1;
                    nxt_st.nmi_branch = st_ff.wake_nmi;
                    nxt_st.irq_ack    = !st_ff.wake_nmi &&
                                        st_ff.wake_ack_ok;
                end
            end
            default:
            begin
                nxt_st.mode = ssic_pkg::ST_NORMAL;
            end
        endcase

        // Clock and unit enables follow the next mode
        case (nxt_st.mode)
            ssic_pkg::ST_IDLE:
            begin
                nxt_st.main_osc_en      = 1'b1;
                nxt_st.cpu_clk_en       = 1'b0;
                nxt_st.periph_clk_en    = 1'b1;
                nxt_st.port_hold        = 1'b1;
                nxt_st.state_freeze     = 1'b1;
                nxt_st.rto_run          = rto_on_timer8_irq &&
                                          timer8_idle_enable;
                nxt_st.rto_buffer_wr_en = 1'b0;
                nxt_st.uart_a_run       = uart_ext_baud_clock;
                nxt_st.uart_b_run       = 1'b0;
                nxt_st.csi_a_run        = csi_ext_serial_clock_a;
                nxt_st.csi_b_run        = csi_ext_serial_clock_b;
                nxt_st.auto_xfer_run    = 1'b0;
                nxt_st.two_wire_run     = 1'b0;
                nxt_st.adc_allow        = 1'b0;
            end
            ssic_pkg::ST_STOP, ssic_pkg::ST_STAB:
            begin
                // Oscillator restarts while the interval is counted
                nxt_st.main_osc_en      = (nxt_st.mode ==
                                           ssic_pkg::ST_STAB);
                nxt_st.cpu_clk_en       = 1'b0;
                nxt_st.periph_clk_en    = 1'b0;
                nxt_st.port_hold        = 1'b1;
                nxt_st.state_freeze     = 1'b1;
                nxt_st.rto_run          = 1'b0;
                nxt_st.rto_buffer_wr_en = 1'b0;
                nxt_st.uart_a_run       = uart_ext_baud_clock;
                nxt_st.uart_b_run       = 1'b0;
                nxt_st.csi_a_run        = csi_ext_serial_clock_a;
                nxt_st.csi_b_run        = csi_ext_serial_clock_b;
                nxt_st.auto_xfer_run    = 1'b0;
                nxt_st.two_wire_run     = 1'b0;
                nxt_st.adc_allow        = 1'b0;
            end
            default:
            begin
                nxt_st.main_osc_en      = 1'b1;
                nxt_st.cpu_clk_en       = 1'b1;
                nxt_st.periph_clk_en    = 1'b1;
                nxt_st.port_hold        = 1'b0;
                nxt_st.state_freeze     = 1'b0;
                nxt_st.rto_run          = 1'b1;
                nxt_st.rto_buffer_wr_en = 1'b1;
                nxt_st.uart_a_run       = 1'b1;
                nxt_st.uart_b_run       = 1'b1;
                nxt_st.csi_a_run        = 1'b1;
                nxt_st.csi_b_run        = 1'b1;
                nxt_st.auto_xfer_run    = 1'b1;
                nxt_st.two_wire_run     = 1'b1;
                nxt_st.adc_allow        = 1'b1;
            end
        endcase
        nxt_st.sub_osc_en   = 1'b1;
        nxt_st.key_irq_en   = 1'b1;
        nxt_st.regulator_en = 1'b1;

        if (wdt_rst_hit)
        begin
            nxt_st           = RST_STATE;
            nxt_st.reset_req = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            st_ff <= RST_STATE;
        else
            st_ff <= nxt_st;
    end

    ssic_stab_cnt u_stab_cnt
    (
        .clk        (clk),
        .srst       (srst),
        .load       (st_ff.stab_load),
        .load_value (stab_cycles),
        .done       (stab_done)
    );

    assign mode                 = st_ff.mode;
    assign main_osc_en          = st_ff.main_osc_en;
    assign sub_osc_en           = st_ff.sub_osc_en;
    assign cpu_clk_en           = st_ff.cpu_clk_en;
    assign periph_clk_en        = st_ff.periph_clk_en;
    assign port_hold            = st_ff.port_hold;
    assign state_freeze         = st_ff.state_freeze;
    assign rto_run              = st_ff.rto_run;
    assign rto_buffer_wr_en     = st_ff.rto_buffer_wr_en;
    assign async_serial_a_run   = st_ff.uart_a_run;
    assign async_serial_b_run   = st_ff.uart_b_run;
    assign clocked_serial_a_run = st_ff.csi_a_run;
    assign clocked_serial_b_run = st_ff.csi_b_run;
    assign auto_transfer_run    = st_ff.auto_xfer_run;
    assign two_wire_run         = st_ff.two_wire_run;
    assign adc_allow            = st_ff.adc_allow;
    assign key_irq_en           = st_ff.key_irq_en;
    assign regulator_en         = st_ff.regulator_en;
    assign wake_done            = st_ff.wake_done;
    assign nmi_branch           = st_ff.nmi_branch;
    assign irq_ack              = st_ff.irq_ack;
    assign reset_req            = st_ff.reset_req;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_stop_release;
        st_ff.mode == ssic_pkg::ST_STOP && wake_any && !wdt_rst_hit;
    endsequence

    sequence s_stab_end;
        st_ff.mode == ssic_pkg::ST_STAB && stab_done && !wdt_rst_hit;
    endsequence

    property p_stop_entry;
        st_ff.mode == ssic_pkg::ST_NORMAL && stop_trigger &&
        power_save_select == ssic_pkg::SEL_STOP
        |=> st_ff.mode == ssic_pkg::ST_STOP && !main_osc_en;
    endproperty
    a_stop_entry: assert property (p_stop_entry)
        else $error("stop not entered on trigger");

    property p_hold_in_standby;
        st_ff.mode != ssic_pkg::ST_NORMAL && !wake_any && !wdt_rst_hit &&
        st_ff.mode != ssic_pkg::ST_STAB |=> $stable(st_ff.mode);
    endproperty
    a_hold_in_standby: assert property (p_hold_in_standby)
        else $error("standby left without a valid release");

    property p_stop_clocks;
        st_ff.mode == ssic_pkg::ST_STOP |-> !main_osc_en && sub_osc_en &&
        !cpu_clk_en && !periph_clk_en && state_freeze;
    endproperty
    a_stop_clocks: assert property (p_stop_clocks)
        else $error("clocks not gated in stop");

    property p_stop_release;
        s_stop_release |=> st_ff.mode == ssic_pkg::ST_STAB && main_osc_en &&
        !cpu_clk_en;
    endproperty
    a_stop_release: assert property (p_stop_release)
        else $error("stop release did not start stabilization");

    property p_stab_wait;
        st_ff.mode == ssic_pkg::ST_STAB && !stab_done && !wdt_rst_hit
        |=> !cpu_clk_en;
    endproperty
    a_stab_wait: assert property (p_stab_wait)
        else $error("CPU clocked before stabilization ended");

    property p_stab_end;
        s_stab_end |=> cpu_clk_en && wake_done &&
        st_ff.mode == ssic_pkg::ST_NORMAL;
    endproperty
    a_stab_end: assert property (p_stab_end)
        else $error("normal mode not restored after stabilization");

    property p_low_prio;
        st_ff.mode == ssic_pkg::ST_IDLE && maskable_req && !nmi_req &&
        in_service && request_priority >= service_priority && !wdt_rst_hit
        |=> wake_done && !irq_ack && !nmi_branch;
    endproperty
    a_low_prio: assert property (p_low_prio)
        else $error("lower priority request was acknowledged");

    property p_nmi_branch;
        st_ff.mode == ssic_pkg::ST_IDLE && nmi_req && !wdt_rst_hit
        |=> nmi_branch && !irq_ack;
    endproperty
    a_nmi_branch: assert property (p_nmi_branch)
        else $error("non-maskable release did not branch");

    property p_idle_units;
        st_ff.mode == ssic_pkg::ST_IDLE |-> port_hold && !cpu_clk_en &&
        !async_serial_b_run && !auto_transfer_run && !two_wire_run &&
        !rto_buffer_wr_en && key_irq_en && regulator_en;
    endproperty
    a_idle_units: assert property (p_idle_units)
        else $error("idle unit enables wrong");

    property p_wdt_reset;
        wdt_rst_hit |=> reset_req && st_ff.mode == ssic_pkg::ST_NORMAL &&
        cpu_clk_en;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset)
        else $error("watchdog reset did not restore reset state");

endmodule : ssic_ctrl

// file: tb/ssic_src_model.sv
`timescale 1ns/1ns
module ssic_src_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Command from the bench
    input  wire logic       go,
    input  wire logic [2:0] cmd,
    // Served indications
    input  wire logic       wake_done,
    input  wire logic       reset_req,
    // Release sources, held until served
    output logic            nmi_pin,
    output logic            second_watchdog_irq,
    output logic            second_watchdog_reset,
    output logic [6:0]      ext_irq,
    output logic [7:0]      periph_irq
);
    // Requests stay pending until the controller reports a wake-up or a reset
    always_ff @(posedge clk)
    begin
        if (srst || wake_done || reset_req)
        begin
            nmi_pin               <= 1'b0;
            second_watchdog_irq   <= 1'b0;
            second_watchdog_reset <= 1'b0;
            ext_irq               <= 7'h00;
            periph_irq            <= 8'h00;
        end
        else if (go)
        begin
            nmi_pin               <= (cmd == 3'h0);
            ext_irq[6]            <= (cmd == 3'h1);
            periph_irq[7]         <= (cmd == 3'h2);
            second_watchdog_irq   <= (cmd == 3'h3);
            second_watchdog_reset <= (cmd == 3'h4);
        end
    end
endmodule : ssic_src_model

// file: tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, srst = 1'b1, go = 1'b0, power_save_select = 1'b0;
    logic stop_trigger = 1'b0, wdt_nmi_release_mask = 1'b0, on_subclock = 1'b0;
    logic pin_nmi_release_mask = 1'b0, maskable_release_mask = 1'b0;
    logic irq_enabled = 1'b1, in_service = 1'b0, uart_ext_baud_clock = 1'b0;
    logic csi_ext_serial_clock_a = 1'b0, csi_ext_serial_clock_b = 1'b0;
    logic rto_on_timer8_irq = 1'b0, timer8_idle_enable = 1'b0;
    logic [2:0] cmd = 3'h0, service_priority = 3'h3, request_priority = 3'h3;
    logic [6:0] ext_irq_mask = 7'h00, ext_irq;
    logic [7:0] periph_irq_mask = 8'h00, periph_irq;
    logic [15:0] stab_cycles = 16'h0004;
    logic nmi_pin, second_watchdog_irq, second_watchdog_reset, port_hold;
    logic main_osc_en, sub_osc_en, cpu_clk_en, periph_clk_en, state_freeze;
    logic rto_run, rto_buffer_wr_en, async_serial_a_run, async_serial_b_run;
    logic clocked_serial_a_run, clocked_serial_b_run, auto_transfer_run;
    logic two_wire_run, adc_allow, key_irq_en, regulator_en, wake_done;
    logic nmi_branch, irq_ack, reset_req;
    ssic_pkg::ssic_mode_t mode;
    int n_errors = 0;
    int compares = 0;
    wire [7:0] stdby = {main_osc_en, sub_osc_en, cpu_clk_en, periph_clk_en,
                        port_hold, state_freeze, mode};
    wire [13:0] idlev = {port_hold, state_freeze, cpu_clk_en, main_osc_en,
        async_serial_a_run, async_serial_b_run, clocked_serial_a_run,
        clocked_serial_b_run, auto_transfer_run, two_wire_run, key_irq_en,
        regulator_en, rto_run, rto_buffer_wr_en};

    always #20 clk = ~clk;

    ssic_ctrl dut
    (
        .clk, .srst, .power_save_select, .stop_trigger, .wdt_nmi_release_mask,
        .pin_nmi_release_mask, .maskable_release_mask, .stab_cycles, .nmi_pin,
        .on_subclock, .second_watchdog_irq, .second_watchdog_reset, .ext_irq,
        .ext_irq_mask, .periph_irq, .periph_irq_mask, .irq_enabled,
        .in_service, .service_priority, .request_priority,
        .uart_ext_baud_clock, .csi_ext_serial_clock_a, .csi_ext_serial_clock_b,
        .rto_on_timer8_irq, .timer8_idle_enable, .main_osc_en, .sub_osc_en,
        .cpu_clk_en, .periph_clk_en, .port_hold, .state_freeze, .rto_run,
        .rto_buffer_wr_en, .async_serial_a_run, .async_serial_b_run,
        .clocked_serial_a_run, .clocked_serial_b_run, .auto_transfer_run,
        .two_wire_run, .adc_allow, .key_irq_en, .regulator_en, .wake_done,
        .nmi_branch, .irq_ack, .reset_req, .mode
    );

    ssic_src_model src
    (
        .clk, .srst, .go, .cmd, .wake_done, .reset_req, .nmi_pin,
        .second_watchdog_irq, .second_watchdog_reset, .ext_irq, .periph_irq
    );

    task automatic close_out;
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_pulse(input logic rst);
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clk);
            #1;
            if ((rst ? reset_req : wake_done) === 1'b1)
                return;
        end
        chk(16'h0000, 16'h0001);
        close_out();
    endtask : wait_pulse

    // A wait that ran out of cycles ends the run as a failure
    task automatic limit(input logic hit);
        if (!hit)
        begin
            chk(16'h0000, 16'h0001);
            close_out();
        end
    endtask : limit

    task automatic enter(input logic s);
        @(posedge clk);
        power_save_select <= s;
        stop_trigger      <= 1'b1;
        @(posedge clk);
        stop_trigger <= 1'b0;
        #1;
        chk(16'(mode), s ? 16'h0002 : 16'h0001);
        repeat (5) @(posedge clk);
        #1;
    endtask : enter

    task automatic raise(input logic [2:0] c);
        @(posedge clk);
        go  <= 1'b1;
        cmd <= c;
        @(posedge clk);
        go <= 1'b0;
    endtask : raise

    task automatic set_masks(input logic m);
        @(posedge clk);
        maskable_release_mask <= m;
        pin_nmi_release_mask  <= m;
        wdt_nmi_release_mask  <= m;
        ext_irq_mask          <= {7{m}};
        periph_irq_mask       <= {8{m}};
    endtask : set_masks

    task automatic sc_stop;
        int n;
        enter(1'b1);
        chk(16'(stdby), 16'h004e);
        set_masks(1'b1);
        raise(3'h1);
        repeat (8) @(posedge clk);
        #1;
        chk(16'(mode), 16'h0002);
        set_masks(1'b0);
        for (n = 0; mode !== ssic_pkg::ST_STAB && n < 8; n++)
        begin
            @(posedge clk);
            #1;
        end
        limit(mode === ssic_pkg::ST_STAB);
        chk(16'({mode, cpu_clk_en, main_osc_en}), 16'h000d);
        for (n = 0; mode === ssic_pkg::ST_STAB && n < 64; n++)
        begin
            @(posedge clk);
            #1;
        end
        limit(n < 64);
        chk(n[15:0], stab_cycles + 16'h0002);
        chk(16'({mode, cpu_clk_en, wake_done, irq_ack}),
            16'h0007);
    endtask : sc_stop

    task automatic sc_idle;
        @(posedge clk);
        uart_ext_baud_clock    <= 1'b1;
        csi_ext_serial_clock_a <= 1'b1;
        rto_on_timer8_irq      <= 1'b1;
        timer8_idle_enable     <= 1'b1;
        enter(1'b0);
        chk(16'(idlev), 16'h368e);
        chk(16'({adc_allow, periph_clk_en}), 16'h0001);
    endtask : sc_idle

    task automatic sc_wake(input logic [2:0] c, input logic svc,
                           input logic [2:0] rp, input logic e,
                           input logic [1:0] ex);
        @(posedge clk);
        in_service       <= svc;
        request_priority <= rp;
        irq_enabled      <= e;
        enter(1'b0);
        raise(c);
        wait_pulse(1'b0);
        if (c == 3'h0 || c == 3'h3)
            chk(16'({nmi_branch, irq_ack}), 16'h0002);
        else
            chk(16'({nmi_branch, irq_ack}), 16'(ex));
        chk(16'(mode), 16'h0000);
    endtask : sc_wake

    task automatic sc_wdt_reset;
        enter(1'b1);
        chk(16'({async_serial_a_run, clocked_serial_a_run,
                 clocked_serial_b_run}), 16'h0006);
        raise(3'h4);
        wait_pulse(1'b1);
        chk(16'(stdby), 16'h00f0);
    endtask : sc_wdt_reset

    initial
    begin
        repeat (16) @(posedge clk);
        srst        <= 1'b0;
        on_subclock <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(stdby), 16'h00f0);
        sc_stop();
        sc_idle();
        sc_wake(3'h1, 1'b1, 3'h5, 1'b1, 2'b00);
        sc_wake(3'h2, 1'b1, 3'h1, 1'b1, 2'b01);
        sc_wake(3'h0, 1'b1, 3'h5, 1'b1, 2'b10);
        sc_wake(3'h3, 1'b0, 3'h5, 1'b1, 2'b10);
        sc_wake(3'h1, 1'b0, 3'h1, 1'b0, 2'b00);
        sc_wdt_reset();
        close_out();
    end
endmodule : testbench
